// >>> design/dmss_regs.sv
// status and measurement register bank of a two-channel motor stage
`include "dmss_consts.svh"
module dmss_regs
  import dmss_pkg::*;
#(
  parameter dmss_word_t FW_VERSION = 16'h0001  // arbitrary value
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             page_sel,       // page one selected
  input  wire logic             reg_ch,         // channel instance
  input  wire dmss_addr_t       reg_addr,
  input  wire logic             reg_rd,
  input  wire logic             reg_wr,
  output      dmss_word_t       reg_rdata,
  output      logic             reg_ack,
  input  wire logic [1:0][15:0] coil_mv,
  input  wire dmss_word_t       supply_mv,
  input  wire dmss_word_t       contact_mv,
  input  wire logic [1:0][15:0] coil_ma,        // signed
  input  wire dmss_word_t       temp_c,         // signed
  input  wire logic [1:0][15:0] duty_pct,
  input  wire logic [1:0][15:0] ctrl_err,
  input  wire logic [1:0][15:0] limit_ma,
  input  wire logic [1:0][15:0] abs_ma,
  input  wire logic [1:0][15:0] mean_ma,
  input  wire logic [1:0][15:0] sync_ofs,
  input  wire logic [1:0][15:0] ovl_ms,
  input  wire dmss_word_t       nominal_supply_voltage_setting,
  input  wire dmss_word_t       ovl_time_ms,    // configured limit
  input  wire logic [1:0]       short_det,
  input  wire logic [1:0]       saturated,
  input  wire logic [1:0]       drive_neg,
  input  wire logic [1:0]       drive_pos,
  input  wire logic [1:0]       ready_en,
  input  wire logic [1:0]       active,
  output      logic [1:0]       chan_disable,
  output      logic             status_byte_error_flag
);

  // =====================================================
  // shared supply, contact and temperature checks
  dmss_prod_t sup_x100;   // supply scaled by one hundred
  dmss_prod_t nom_ov;     // nominal times 110
  dmss_prod_t nom_uv;     // nominal times 80
  logic       uv_err;     // supply below 8 V
  logic       ot_err;     // temperature over 100 C
  logic       ot_warn;    // temperature over 80 C
  logic       ov_warn;    // supply 10 % high
  logic       uv_warn;    // supply at 80 % of nominal
  logic       noctrl;     // contact voltage missing

  // products are widened first so no bits fall off
  assign sup_x100 = {8'h00, supply_mv} * `DMSS_FULL_PCT;
  assign nom_ov   = {8'h00, nominal_supply_voltage_setting} * `DMSS_OV_PCT;
  assign nom_uv   = {8'h00, nominal_supply_voltage_setting} * `DMSS_UV_PCT;
  assign ov_warn  = sup_x100 > nom_ov;                 // R15
  assign uv_warn  = sup_x100 <= nom_uv;                // R16
  assign uv_err   = supply_mv < `DMSS_SUP_MIN;         // R17
  assign noctrl   = contact_mv < `DMSS_CTRL_MIN;       // R13
  // temperature is signed, a frozen stage is no error
  assign ot_warn  = $signed(temp_c) > $signed(`DMSS_TEMP_WARN); // R19
  assign ot_err   = $signed(temp_c) > $signed(`DMSS_TEMP_ERR);  // R20

  // =====================================================
  // per-channel status words
  dmss_word_t stat_q [2];   // live condition word per channel
  dmss_word_t stat_d [2];   // next condition word

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      // assemble the word; untouched bits stay zero
      always_comb begin
        stat_d[ch] = `DMSS_RST_WORD;                            // R25
        stat_d[ch][`DMSS_B_MISC]   = uv_err | ot_err;           // R17
        stat_d[ch][`DMSS_B_NOCTRL] = noctrl;                    // R13
        stat_d[ch][`DMSS_B_SHORT]  = short_det[ch];             // R14
        stat_d[ch][`DMSS_B_OVV]    = ov_warn;                   // R15
        stat_d[ch][`DMSS_B_UNV]    = uv_warn | uv_err;          // R16
        stat_d[ch][`DMSS_B_OVC]    = ovl_ms[ch] > ovl_time_ms;  // R18
        stat_d[ch][`DMSS_B_OVT]    = ot_warn;                   // R19
        stat_d[ch][`DMSS_B_SAT]    = saturated[ch];             // R21
        stat_d[ch][`DMSS_B_NEG]    = drive_neg[ch];             // R22
        stat_d[ch][`DMSS_B_POS]    = drive_pos[ch];             // R23
        stat_d[ch][`DMSS_B_ACT]    = active[ch];                // R24
        stat_d[ch][`DMSS_B_RDY]    = ready_en[ch];              // R24
      end

      // one instance per channel, volatile
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stat_q[ch] <= `DMSS_RST_WORD;                         // R3
        end else begin
          stat_q[ch] <= stat_d[ch];                             // R2
        end
      end
    end
  endgenerate

  // =====================================================
  // escalation to shutdown
  logic shut_q;  // both channels held off

  // level follows the cause; no latching is asked for
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shut_q <= 1'b0;
    end else begin
      shut_q <= uv_err | ot_err;                                // R17 R20
    end
  end

  assign chan_disable           = {2{shut_q}};
  assign status_byte_error_flag = shut_q;

  // =====================================================
  // register read path
  dmss_word_t rdata_d;   // selected word
  dmss_word_t rdata_q;   // registered answer
  logic       ack_q;     // answer strobe

  // page one decode; page zero upper holds config kept elsewhere
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_addr == `DMSS_OFS_COND) begin
      rdata_d = stat_q[reg_ch];                                 // R2
    end else if (page_sel && reg_addr[5]) begin                 // R1
      case (reg_addr)
        `DMSS_OFS_LIVE_CH1: rdata_d = stat_q[0];                // R3
        `DMSS_OFS_LIVE_CH2: rdata_d = stat_q[1];                // R3
        `DMSS_OFS_COIL_V1:  rdata_d = coil_mv[0];               // R4
        `DMSS_OFS_COIL_V2:  rdata_d = coil_mv[1];               // R4
        `DMSS_OFS_SUPPLY:   rdata_d = supply_mv;                // R4
        `DMSS_OFS_CONTACT:  rdata_d = contact_mv;               // R4
        `DMSS_OFS_CUR1:     rdata_d = coil_ma[0];               // R5
        `DMSS_OFS_CUR2:     rdata_d = coil_ma[1];               // R5
        `DMSS_OFS_TEMP:     rdata_d = temp_c;                   // R6
        `DMSS_OFS_DUTY1:    rdata_d = duty_pct[0];              // R7
        `DMSS_OFS_DUTY2:    rdata_d = duty_pct[1];              // R7
        `DMSS_OFS_CERR1:    rdata_d = ctrl_err[0];              // R7
        `DMSS_OFS_CERR2:    rdata_d = ctrl_err[1];              // R7
        `DMSS_OFS_LIM1:     rdata_d = limit_ma[0];              // R8
        `DMSS_OFS_LIM2:     rdata_d = limit_ma[1];              // R8
        `DMSS_OFS_ABS1:     rdata_d = abs_ma[0];                // R9
        `DMSS_OFS_ABS2:     rdata_d = abs_ma[1];                // R9
        `DMSS_OFS_MEAN1:    rdata_d = mean_ma[0];               // R9
        `DMSS_OFS_MEAN2:    rdata_d = mean_ma[1];               // R9
        `DMSS_OFS_OFFS1:    rdata_d = sync_ofs[0];              // R10
        `DMSS_OFS_OFFS2:    rdata_d = sync_ofs[1];              // R10
        `DMSS_OFS_OVL1:     rdata_d = ovl_ms[0];                // R11
        `DMSS_OFS_OVL2:     rdata_d = ovl_ms[1];                // R11
        `DMSS_OFS_FW:       rdata_d = FW_VERSION;               // R12
        default:            rdata_d = 16'h0000;                 // R12
      endcase
    end
  end

  // answer one cycle after the request; writes only acknowledged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= reg_rd | reg_wr;
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_ack   = ack_q;

  // =====================================================
  // checks
  property p_r13;
    @(posedge clk) disable iff (rst)
    !rst && (contact_mv < `DMSS_CTRL_MIN) |=> stat_q[0][`DMSS_B_NOCTRL];
  endproperty
  a_r13: assert property (p_r13) else $error("no contact power flag"); // R13

  // the release edge still clears the words, so sampled reset gates each start
  property p_r14;
    @(posedge clk) disable iff (rst)
    !rst && short_det[1] |=> stat_q[1][`DMSS_B_SHORT];
  endproperty
  a_r14: assert property (p_r14) else $error("short flag missing"); // R14

  property p_r17;
    @(posedge clk) disable iff (rst)
    !rst && uv_err |=> (chan_disable == 2'b11) && status_byte_error_flag
               && stat_q[0][`DMSS_B_MISC] && stat_q[1][`DMSS_B_UNV];
  endproperty
  a_r17: assert property (p_r17) else $error("undervoltage shutdown"); // R17

  property p_r20;
    @(posedge clk) disable iff (rst)
    !rst && ot_err |=> stat_q[1][`DMSS_B_MISC] && stat_q[1][`DMSS_B_OVT]
               && (chan_disable == 2'b11);
  endproperty
  a_r20: assert property (p_r20) else $error("overtemp shutdown"); // R20

  property p_r25;
    @(posedge clk) disable iff (rst)
    (stat_q[0][1:0] == 2'b00) && !stat_q[0][7] && !stat_q[0][13]
    && (stat_q[1][1:0] == 2'b00) && !stat_q[1][7] && !stat_q[1][13];
  endproperty
  a_r25: assert property (p_r25) else $error("reserved bit set"); // R25

  property p_r3;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_LIVE_CH2)
    |=> reg_ack && (reg_rdata == $past(stat_q[1]));
  endproperty
  a_r3: assert property (p_r3) else $error("live word ch2 read"); // R3

  property p_r12;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_FW)
    |=> reg_rdata == FW_VERSION;
  endproperty
  a_r12: assert property (p_r12) else $error("firmware version read"); // R12

  property p_r1;
    @(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `DMSS_OFS_SUPPLY)
    |=> reg_rdata == ($past(page_sel) ? $past(supply_mv) : 16'h0000);
  endproperty
  a_r1: assert property (p_r1) else $error("page select decode"); // R1

  property p_r2;
    @(posedge clk) disable iff (rst)
    reg_rd && (reg_addr == `DMSS_OFS_COND)
    |=> reg_rdata == ($past(reg_ch) ? $past(stat_q[1]) : $past(stat_q[0]));
  endproperty
  a_r2: assert property (p_r2) else $error("channel instance read"); // R2

  property p_r23;
    @(posedge clk) disable iff (rst)
    !rst && drive_pos[0] && !drive_neg[0] |=> stat_q[0][`DMSS_B_POS]
                                      && !stat_q[0][`DMSS_B_NEG];
  endproperty
  a_r23: assert property (p_r23) else $error("direction flags"); // R23

  property p_r4;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_COIL_V1)
    |=> reg_ack && (reg_rdata == $past(coil_mv[0]));
  endproperty
  a_r4: assert property (p_r4) else $error("coil voltage read"); // R4

  property p_r5;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_CUR2)
    |=> reg_ack && (reg_rdata == $past(coil_ma[1]));
  endproperty
  a_r5: assert property (p_r5) else $error("coil current read"); // R5

  property p_r6;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_TEMP)
    |=> reg_ack && (reg_rdata == $past(temp_c));
  endproperty
  a_r6: assert property (p_r6) else $error("temperature read"); // R6

  property p_r7;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_DUTY2)
    |=> reg_ack && (reg_rdata == $past(duty_pct[1]));
  endproperty
  a_r7: assert property (p_r7) else $error("duty cycle read"); // R7

  property p_r8;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_LIM1)
    |=> reg_ack && (reg_rdata == $past(limit_ma[0]));
  endproperty
  a_r8: assert property (p_r8) else $error("current limit read"); // R8

  property p_r9;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_MEAN2)
    |=> reg_ack && (reg_rdata == $past(mean_ma[1]));
  endproperty
  a_r9: assert property (p_r9) else $error("mean current read"); // R9

  property p_r10;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_OFFS1)
    |=> reg_ack && (reg_rdata == $past(sync_ofs[0]));
  endproperty
  a_r10: assert property (p_r10) else $error("current offset read"); // R10

  property p_r11;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr == `DMSS_OFS_OVL2)
    |=> reg_ack && (reg_rdata == $past(ovl_ms[1]));
  endproperty
  a_r11: assert property (p_r11) else $error("overload duration read"); // R11

  property p_r12_rsvd;
    @(posedge clk) disable iff (rst)
    reg_rd && page_sel && (reg_addr > `DMSS_OFS_OVL2) && (reg_addr < `DMSS_OFS_FW)
    |=> reg_ack && (reg_rdata == 16'h0000);
  endproperty
  a_r12_rsvd: assert property (p_r12_rsvd) else $error("reserved read"); // R12

  property p_r15;
    @(posedge clk) disable iff (rst)
    !rst && (({8'h00, supply_mv} * `DMSS_FULL_PCT) >
             ({8'h00, nominal_supply_voltage_setting} * `DMSS_OV_PCT))
    |=> stat_q[0][`DMSS_B_OVV] && stat_q[1][`DMSS_B_OVV];
  endproperty
  a_r15: assert property (p_r15) else $error("overvoltage warning"); // R15

  property p_r16;
    @(posedge clk) disable iff (rst)
    !rst && (({8'h00, supply_mv} * `DMSS_FULL_PCT) <=
             ({8'h00, nominal_supply_voltage_setting} * `DMSS_UV_PCT))
    |=> stat_q[0][`DMSS_B_UNV] && stat_q[1][`DMSS_B_UNV];
  endproperty
  a_r16: assert property (p_r16) else $error("undervoltage warning"); // R16

  property p_r18;
    @(posedge clk) disable iff (rst)
    !rst && (ovl_ms[1] > ovl_time_ms) |=> stat_q[1][`DMSS_B_OVC];
  endproperty
  a_r18: assert property (p_r18) else $error("overcurrent warning"); // R18

  property p_r19;
    @(posedge clk) disable iff (rst)
    !rst && ($signed(temp_c) > $signed(`DMSS_TEMP_WARN))
    |=> stat_q[0][`DMSS_B_OVT] && stat_q[1][`DMSS_B_OVT];
  endproperty
  a_r19: assert property (p_r19) else $error("temperature warning"); // R19

  property p_r21;
    @(posedge clk) disable iff (rst)
    !rst && saturated[0] |=> stat_q[0][`DMSS_B_SAT];
  endproperty
  a_r21: assert property (p_r21) else $error("saturation flag"); // R21

  property p_r24;
    @(posedge clk) disable iff (rst)
    !rst && ready_en[0] && active[1]
    |=> stat_q[0][`DMSS_B_RDY] && stat_q[1][`DMSS_B_ACT];
  endproperty
  a_r24: assert property (p_r24) else $error("ready flags"); // R24

  // a write is answered but must leave the read data alone
  property p_wr;
    @(posedge clk) disable iff (rst)
    reg_wr && !reg_rd |=> reg_ack && $stable(reg_rdata);
  endproperty
  a_wr: assert property (p_wr) else $error("write changed read data"); // R25

  property p_cov_uv;
    @(posedge clk) disable iff (rst) uv_err ##1 chan_disable[0];
  endproperty
  c_uv: cover property (p_cov_uv);

  property p_cov_rd;
    @(posedge clk) disable iff (rst) reg_rd && page_sel ##1 reg_ack;
  endproperty
  c_rd: cover property (p_cov_rd);

  property p_cov_ovc;
    @(posedge clk) disable iff (rst) stat_q[1][`DMSS_B_OVC];
  endproperty
  c_ovc: cover property (p_cov_ovc);

  property p_cov_ot;
    @(posedge clk) disable iff (rst) ot_err ##1 status_byte_error_flag;
  endproperty
  c_ot: cover property (p_cov_ot);

  property p_cov_wr;
    @(posedge clk) disable iff (rst) reg_wr ##1 reg_ack;
  endproperty
  c_wr: cover property (p_cov_wr);

endmodule // dmss_regs

// >>> dv/dmss_coupler.sv
// bus coupler model that issues register reads and writes
module dmss_coupler
  import dmss_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reg_ack,
  input  wire dmss_word_t reg_rdata,
  output      logic       reg_rd,
  output      logic       reg_wr,
  output      logic       reg_ch,
  output      dmss_addr_t reg_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // idle bus at time zero
  initial begin
    reg_rd   = 1'b0;
    reg_wr   = 1'b0;
    reg_ch   = 1'b0;
    reg_addr = 6'h00;
  end
  // one transfer; answer is expected exactly one cycle after it is taken
  task automatic xfer(input logic wr, input logic ch, input dmss_addr_t a,
                      output dmss_word_t d, output logic ok);
    @(posedge clk);
    reg_rd   <= ~wr;
    reg_wr   <= wr;
    reg_ch   <= ch;
    reg_addr <= a;
    @(posedge clk);
    // released address shows its inverse so a stale value never matches
    reg_rd   <= 1'b0;
    reg_wr   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    ok = (reg_ack === 1'b1);
    d  = reg_rdata;
  endtask
endmodule // dmss_coupler

// >>> dv/tb_top.sv
// self-checking bench for the motor stage status register bank
module tb_top import dmss_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {dmss_word_t s; dmss_word_t t; dmss_word_t c;} dmss_step_t;
  localparam dmss_word_t FW = 16'h5a3c;  // arbitrary version code
  logic             clk, rst, page_sel, reg_rd, reg_wr, reg_ch, reg_ack, flag, ok;
  dmss_addr_t       reg_addr;
  dmss_word_t       reg_rdata, sup, con, tmp, nom, ovt, rd_d, ex;
  logic [1:0][15:0] cmv, cma, dty, cer, lim, abm, mnm, sof, ovl;
  logic [1:0]       shd, sat, neg, pos, rdy, act, dis;
  int               n_mismatch = 0;
  int               cmp_count = 0;
  int               cyc = 0;
  // supply, temperature and contact rows around every threshold
  dmss_step_t steps [11] = '{
    '{16'h1f3f, 16'h0028, 16'h2ee0}, '{16'h1f40, 16'h0028, 16'h2ee0},
    '{16'h7d00, 16'h0028, 16'h2ee0}, '{16'h7d01, 16'h0028, 16'h2ee0},
    '{16'habe0, 16'h0028, 16'h2ee0}, '{16'habe1, 16'h0028, 16'h2ee0},
    '{16'h9000, 16'h0050, 16'h2ee0}, '{16'h9000, 16'h0051, 16'h2ee0},
    '{16'h9000, 16'h0064, 16'h2ee0}, '{16'h9000, 16'h0065, 16'h2ee0},
    '{16'h9000, 16'h0028, 16'h2edf}};
  // ==========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin  // about fifteen times the expected run
      n_mismatch++;
      end_sim();
    end
  end
  dmss_coupler cpl (.clk(clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .reg_rd(reg_rd),
                    .reg_wr(reg_wr), .reg_ch(reg_ch), .reg_addr(reg_addr));
  dmss_regs #(.FW_VERSION(FW)) dut (.clk(clk), .rst(rst), .page_sel(page_sel),
    .reg_ch(reg_ch), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .coil_mv(cmv), .supply_mv(sup),
    .contact_mv(con), .coil_ma(cma), .temp_c(tmp), .duty_pct(dty), .ctrl_err(cer),
    .limit_ma(lim), .abs_ma(abm), .mean_ma(mnm), .sync_ofs(sof), .ovl_ms(ovl),
    .nominal_supply_voltage_setting(nom), .ovl_time_ms(ovt), .short_det(shd),
    .saturated(sat), .drive_neg(neg), .drive_pos(pos), .ready_en(rdy), .active(act),
    .chan_disable(dis), .status_byte_error_flag(flag));
  // ==========================================
  // checking helpers
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input dmss_word_t got, input dmss_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic wr, input logic ch, input dmss_addr_t a);
    cpl.xfer(wr, ch, a, rd_d, ok);
    chk({15'h0000, ok}, 16'h0001);
  endtask
  // expected status word worked out from the thresholds
  function automatic dmss_word_t ew(input int c);
    logic [31:0] s;
    dmss_word_t  w;
    s = {16'h0000, sup} * 32'h64;
    w = 16'h0000;  // reserved bits stay zero
    w[15] = (sup < 16'h1f40) || ($signed(tmp) > $signed(16'h0064));
    w[14] = con < 16'h2ee0;
    w[12] = shd[c];
    w[11] = s > {16'h0000, nom} * 32'h6e;
    w[10] = (s <= {16'h0000, nom} * 32'h50) || (sup < 16'h1f40);
    w[9]  = ovl[c] > ovt;
    w[8]  = $signed(tmp) > $signed(16'h0050);
    w[6]  = sat[c];
    w[5]  = neg[c];
    w[4]  = pos[c];
    w[3]  = act[c];
    w[2]  = rdy[c];
    return w;
  endfunction
  task automatic chk_status();
    dmss_word_t w0;  // expected word of channel one
    for (int c = 0; c < 2; c++) begin
      rd(1'b0, c[0], 6'h00);
      chk(rd_d, ew(c));
      rd(1'b0, 1'b0, 6'h20 + 6'(c));
      chk(rd_d, ew(c));
    end
    w0 = ew(0);
    chk({14'h0000, dis}, {14'h0000, {2{w0[15]}}});
    chk({15'h0000, flag}, ew(1) >> 15);
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    page_sel = 1'b1;
    {cmv, sup, con} = {16'ha023, 16'ha022, 16'ha024, 16'ha025};
    {cma, tmp, dty} = {16'ha027, 16'ha026, 16'ha028, 16'ha02a, 16'ha029};
    {cer, lim, abm} = {16'ha02c, 16'ha02b, 16'ha02e, 16'ha02d, 16'ha030, 16'ha02f};
    {mnm, sof, ovl} = {16'ha032, 16'ha031, 16'ha034, 16'ha033, 16'ha036, 16'ha035};
    nom = 16'h9c40;  // 40 V nominal
    ovt = 16'ha035;  // channel two one past the limit
    {shd, sat, neg, pos, rdy, act} = {2'b10, 2'b01, 2'b10, 2'b01, 2'b01, 2'b10};
    repeat (8) @(posedge clk);
    chk(reg_rdata, 16'h0000);
    rst <= 1'b0;
    $display("reset test done");
    // every page-one address from 6'h22 up, reserved range and firmware word
    for (int a = 6'h22; a < 7'h40; a++) begin
      ex = (a > 6'h3e) ? FW : (a > 6'h36) ? 16'h0000 : 16'ha000 + 16'(a);
      rd(1'b0, 1'b0, 6'(a));
      chk(rd_d, ex);
    end
    chk_status();
    $display("page one table done");
    foreach (steps[i]) begin
      @(posedge clk);
      {sup, tmp, con} <= {steps[i].s, steps[i].t, steps[i].c};
      repeat (2) @(posedge clk);
      chk_status();
    end
    $display("threshold test done");
    // writes are acked and change nothing
    rd(1'b1, 1'b0, 6'h3f);
    rd(1'b0, 1'b0, 6'h3f);
    chk(rd_d, FW);
    rd(1'b1, 1'b1, 6'h00);
    chk_status();
    page_sel <= 1'b0;
    for (int a = 6'h20; a < 7'h40; a++) begin
      rd(1'b0, 1'b0, 6'(a));
      chk(rd_d, 16'h0000);
    end
    $display("page zero test done");
    // reset in mid-run while an undervoltage shutdown is active
    sup <= 16'h1f3f;
    repeat (3) @(posedge clk);
    chk({14'h0000, dis}, 16'h0003);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk({14'h0000, dis}, 16'h0000);
    chk(reg_rdata, 16'h0000);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({14'h0000, dis}, 16'h0003);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule // tb_top

// >>> inc/dmss_consts.svh
// constants for the motor stage status register bank
// What this block does
// [R1] page one shows measured values up high
// [R2] separate register instance per output channel
// [R3] channel status words at first upper registers
// [R4] coil, supply, contact voltages in millivolts
// [R5] signed coil current per channel, mA
// [R6] driver temperature in whole degrees
// [R7] duty cycle percent and raw control error
// [R8] active current limit per channel, mA
// [R9] absolute and mean absolute coil current
// [R10] synchronization current offset, raw digits
// [R11] overload duration per channel, ms
// [R12] reserved range, firmware version last
// [R13] bit 14 when contact voltage below 12V
// [R14] bit 12 on driver short circuit
// [R15] bit 11 when supply 10% over nominal
// [R16] bit 10 when supply at 80% relation
// [R17] below 8V: error, bit15, flag, shutdown
// [R18] bit 9 when overload time exceeded
// [R19] bit 8 when temperature above 80C
// [R20] above 100C: error, bit15, flag, shutdown
// [R21] bit 6 while output saturated
// [R22] bit 5 while driving negative
// [R23] bit 4 while driving positive
// [R24] bit 2 ready to enable, 3 active
// [R25] reserved status bits read zero
`ifndef DMSS_CONSTS_SVH
`define DMSS_CONSTS_SVH
// =====================================================
// register offsets
`define DMSS_OFS_COND      6'h00
`define DMSS_OFS_LIVE_CH1  6'h20
`define DMSS_OFS_LIVE_CH2  6'h21
`define DMSS_OFS_COIL_V1   6'h22
`define DMSS_OFS_COIL_V2   6'h23
`define DMSS_OFS_SUPPLY    6'h24
`define DMSS_OFS_CONTACT   6'h25
`define DMSS_OFS_CUR1      6'h26
`define DMSS_OFS_CUR2      6'h27
`define DMSS_OFS_TEMP      6'h28
`define DMSS_OFS_DUTY1     6'h29
`define DMSS_OFS_DUTY2     6'h2a
`define DMSS_OFS_CERR1     6'h2b
`define DMSS_OFS_CERR2     6'h2c
`define DMSS_OFS_LIM1      6'h2d
`define DMSS_OFS_LIM2      6'h2e
`define DMSS_OFS_ABS1      6'h2f
`define DMSS_OFS_ABS2      6'h30
`define DMSS_OFS_MEAN1     6'h31
`define DMSS_OFS_MEAN2     6'h32
`define DMSS_OFS_OFFS1     6'h33
`define DMSS_OFS_OFFS2     6'h34
`define DMSS_OFS_OVL1      6'h35
`define DMSS_OFS_OVL2      6'h36
`define DMSS_OFS_FW        6'h3f
// =====================================================
// status word bit positions
`define DMSS_B_MISC   15
`define DMSS_B_NOCTRL 14
`define DMSS_B_SHORT  12
`define DMSS_B_OVV    11
`define DMSS_B_UNV    10
`define DMSS_B_OVC    9
`define DMSS_B_OVT    8
`define DMSS_B_SAT    6
`define DMSS_B_NEG    5
`define DMSS_B_POS    4
`define DMSS_B_ACT    3
`define DMSS_B_RDY    2
// =====================================================
// reset value and thresholds
`define DMSS_RST_WORD   16'h0000
`define DMSS_CTRL_MIN   16'h2ee0
`define DMSS_SUP_MIN    16'h1f40
`define DMSS_TEMP_WARN  16'h0050
`define DMSS_TEMP_ERR   16'h0064
`define DMSS_OV_PCT     24'h00006e
`define DMSS_UV_PCT     24'h000050
`define DMSS_FULL_PCT   24'h000064
`endif

// >>> inc/dmss_pkg.sv
// types shared by the motor stage status register bank
package dmss_pkg;
  typedef logic [15:0] dmss_word_t;  // one 16-bit register
  typedef logic [5:0]  dmss_addr_t;  // register number
  typedef logic [23:0] dmss_prod_t;  // percent products
endpackage
